// ---- shared/pbwp_pkg.sv ----
package pbwp_pkg;
  // configuration byte location and layout
  localparam logic [21:0] CFG_ADDR        = 22'h30000a;
  localparam int          LOCK_BITS       = 4;
  localparam int          B0_POS          = 0;
  localparam int          B1_POS          = 1;
  localparam int          B2_POS          = 2;
  localparam int          B3_POS          = 3;
  localparam logic [7:0]  CFG_RESET       = 8'h0f;
  localparam logic [7:0]  CFG_IMPL_MASK   = 8'h0f;
  localparam logic [3:0]  CFG_SMALL_MASK  = 4'h7;
  // program block ranges
  localparam logic [20:0] B0_LO = 21'h000800;
  localparam logic [20:0] B0_HI = 21'h001fff;
  localparam logic [20:0] B1_LO = 21'h002000;
  localparam logic [20:0] B1_HI = 21'h003fff;
  localparam logic [20:0] B2_LO = 21'h004000;
  localparam logic [20:0] B2_HI = 21'h005fff;
  localparam logic [20:0] B3_LO = 21'h006000;
  localparam logic [20:0] B3_HI = 21'h007fff;

  typedef struct packed {
    logic        valid;
    logic [20:0] addr;
  } pbwp_wr_req_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [21:0] addr;
    logic [7:0] wdata;
  } pbwp_reg_req_t;
endpackage

// ---- hw/pbwp_range_chk.sv ----
`timescale 1ns/1ps
module pbwp_range_chk #(
  parameter logic [20:0] LO = 21'h0,
  parameter logic [20:0] HI = 21'h0
) (
  input  wire logic [20:0] addr,
  input  wire logic        lock_bit,
  output wire logic        blocked
);
  if (HI < LO) begin : g_bad_range
    $error("range upper bound below lower bound");
  end

  wire in_range;
  assign in_range = (addr >= LO) && (addr <= HI);
  // cleared bit blocks its range
  assign blocked = in_range && !lock_bit;
endmodule

// ---- hw/pbwp_top.sv ----
`timescale 1ns/1ps
module pbwp_top #(
  parameter bit SMALL_VARIANT = 1'b0
) (
  input  wire logic                  mclk,
  input  wire logic                  arst_n,
  input  wire logic                  clk_en,
  input  wire logic                  nv_load,
  input  wire logic [7:0]            nv_data,
  input  wire pbwp_pkg::pbwp_reg_req_t reg_req,
  output logic [7:0]                 reg_rdata,
  input  wire pbwp_pkg::pbwp_wr_req_t  flash_req,
  output logic                       flash_grant,
  output logic                       flash_refused,
  output logic [3:0]                 lock_state
);
  import pbwp_pkg::*;

  logic [3:0] cfg_q;
  logic [3:0] cfg_d;
  logic [7:0] rdata_q;
  logic       grant_q;
  logic       refused_q;

  wire        hit_cfg;
  wire        wr_cfg;
  wire        rd_cfg;
  wire [3:0]  impl_mask;
  wire [3:0]  nv_bits;
  wire [3:0]  blocked;
  wire        any_block;

  assign hit_cfg   = (reg_req.addr == CFG_ADDR);
  assign wr_cfg    = reg_req.wr && hit_cfg;
  assign rd_cfg    = reg_req.rd && hit_cfg;
  // bit 3 absent on small parts
  assign impl_mask = SMALL_VARIANT ? CFG_SMALL_MASK : CFG_IMPL_MASK[3:0];
  assign nv_bits   = nv_data[3:0] & impl_mask;

  // load from storage, software clears only
  always_comb begin
    cfg_d = cfg_q;
    if (nv_load) begin
      cfg_d = nv_bits;
    end else if (wr_cfg) begin
      cfg_d = cfg_q & reg_req.wdata[3:0] & impl_mask;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_q <= CFG_RESET[3:0];
    end else if (clk_en) begin
      cfg_q <= cfg_d;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= 8'h00;
    end else if (clk_en) begin
      rdata_q <= rd_cfg ? {4'h0, cfg_q | ~impl_mask} : 8'h00;
    end
  end
  assign reg_rdata = rdata_q;

  pbwp_range_chk #(.LO(B0_LO), .HI(B0_HI)) u_b0 (
    .addr     (flash_req.addr),
    .lock_bit (cfg_q[B0_POS]),
    .blocked  (blocked[0])
  );
  pbwp_range_chk #(.LO(B1_LO), .HI(B1_HI)) u_b1 (
    .addr     (flash_req.addr),
    .lock_bit (cfg_q[B1_POS]),
    .blocked  (blocked[1])
  );
  pbwp_range_chk #(.LO(B2_LO), .HI(B2_HI)) u_b2 (
    .addr     (flash_req.addr),
    .lock_bit (cfg_q[B2_POS]),
    .blocked  (blocked[2])
  );
  pbwp_range_chk #(.LO(B3_LO), .HI(B3_HI)) u_b3 (
    .addr     (flash_req.addr),
    .lock_bit (cfg_q[B3_POS] | ~impl_mask[B3_POS]),
    .blocked  (blocked[3])
  );

  assign any_block = |blocked;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      grant_q   <= 1'b0;
      refused_q <= 1'b0;
    end else if (clk_en) begin
      grant_q   <= flash_req.valid && !any_block;
      refused_q <= flash_req.valid && any_block;
    end
  end
  assign flash_grant   = grant_q;
  assign flash_refused = refused_q;
  assign lock_state    = cfg_q | ~impl_mask;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  a_block3_refuse: assert property (clk_en && flash_req.valid && flash_req.addr >= B3_LO && flash_req.addr <= B3_HI
    && !lock_state[3] |=> flash_refused && !flash_grant) else $error("block 3 write not refused");
  a_block2_refuse: assert property (clk_en && flash_req.valid && flash_req.addr >= B2_LO && flash_req.addr <= B2_HI
    && !cfg_q[2] |=> flash_refused) else $error("block 2 write not refused");
  a_block1_refuse: assert property (clk_en && flash_req.valid && flash_req.addr >= B1_LO && flash_req.addr <= B1_HI
    && !cfg_q[1] |=> flash_refused) else $error("block 1 write not refused");
  a_block0_refuse: assert property (clk_en && flash_req.valid && flash_req.addr >= B0_LO && flash_req.addr <= B0_HI
    && !cfg_q[0] |=> flash_refused) else $error("block 0 write not refused");
  a_open_grant: assert property (clk_en && flash_req.valid && (flash_req.addr < B0_LO || flash_req.addr > B3_HI)
    |=> flash_grant) else $error("unprotected write refused");
  a_clear_only: assert property (clk_en && !nv_load |=> (cfg_q & ~$past(cfg_q)) == 4'h0)
    else $error("lock bit set by software");
  a_read_value: assert property (clk_en && rd_cfg |=> reg_rdata == {4'h0, $past(lock_state)})
    else $error("read data not lock byte");
  a_freeze_hold: assert property (!clk_en |=> cfg_q == $past(cfg_q))
    else $error("lock bits moved while frozen");
  a_block2_open: assert property (clk_en && flash_req.valid && flash_req.addr >= B2_LO && flash_req.addr <= B2_HI
    && cfg_q[2] |=> flash_grant) else $error("block 2 write not granted");
  a_block0_open: assert property (clk_en && flash_req.valid && flash_req.addr >= B0_LO && flash_req.addr <= B0_HI
    && cfg_q[0] |=> flash_grant) else $error("block 0 write not granted");
  a_small_bit3: assert property (SMALL_VARIANT |-> lock_state[3]) else $error("bit 3 not held set");
  a_excl_out: assert property (!(flash_grant && flash_refused)) else $error("grant and refuse together");

  c_refuse: cover property (flash_refused);
  c_grant: cover property (flash_grant);
  c_clear: cover property (clk_en && wr_cfg && !nv_load);
  c_load: cover property (clk_en && nv_load);
endmodule

// ---- verification/test_pbwp_top.sv ----
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fail_count++; $display("Error %0t: got %h want %h", $time, g, e); end end
module test_pbwp_top;
  import pbwp_pkg::*;
  logic          mclk;
  logic          arst_n;
  logic          clk_en;
  logic          nv_load;
  logic [7:0]    nv_data;
  pbwp_reg_req_t reg_req;
  logic [7:0]    reg_rdata;
  logic [7:0]    rdata_s;
  pbwp_wr_req_t  flash_req;
  logic          flash_grant;
  logic          flash_refused;
  logic [3:0]    lock_state;
  logic [3:0]    lock_s;
  int            fail_count;
  int            num_checks;
  logic [20:0]   lo [4] = '{B0_LO, B1_LO, B2_LO, B3_LO};
  logic [20:0]   hi [4] = '{B0_HI, B1_HI, B2_HI, B3_HI};

  pbwp_top i_pbwp_top (.mclk(mclk), .arst_n(arst_n), .clk_en(clk_en), .nv_load(nv_load), .nv_data(nv_data),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .flash_req(flash_req), .flash_grant(flash_grant),
    .flash_refused(flash_refused), .lock_state(lock_state));
  pbwp_top #(.SMALL_VARIANT(1'b1)) i_pbwp_top_small (.mclk(mclk), .arst_n(arst_n), .clk_en(clk_en),
    .nv_load(nv_load), .nv_data(nv_data), .reg_req(reg_req), .reg_rdata(rdata_s), .flash_req(flash_req),
    .flash_grant(), .flash_refused(), .lock_state(lock_s));

  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic reg_op(input logic w, input logic [21:0] a, input logic [7:0] d);
    @(posedge mclk) reg_req <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge mclk) reg_req <= '0;
    #1;
  endtask

  task automatic rd(input logic [21:0] a, input logic [7:0] e);
    reg_op(1'b0, a, 8'h00);
    `CHK(reg_rdata, e)
  endtask

  task automatic fl(input logic [20:0] a, input logic refused);
    @(posedge mclk) flash_req <= '{valid: 1'b1, addr: a};
    @(posedge mclk) flash_req <= '0;
    #1;
    `CHK({flash_grant, flash_refused}, {!refused, refused})
  endtask

  task automatic load(input logic [7:0] d);
    @(posedge mclk) begin nv_load <= 1'b1; nv_data <= d; end
    @(posedge mclk) nv_load <= 1'b0;
    #1;
  endtask

  task automatic t_reset();
    `CHK(lock_state, 4'hf)
    rd(CFG_ADDR, 8'h0f);
    rd(CFG_ADDR + 22'h1, 8'h00);
  endtask

  task automatic t_clear();
    reg_op(1'b1, CFG_ADDR, 8'hfb);
    `CHK(lock_state, 4'hb)
    reg_op(1'b1, CFG_ADDR, 8'hff);
    rd(CFG_ADDR, 8'h0b);
    reg_op(1'b1, CFG_ADDR, 8'hf0);
    rd(CFG_ADDR, 8'h00);
    load(8'hff);
  endtask

  task automatic t_freeze();
    @(posedge mclk) clk_en <= 1'b0;
    reg_op(1'b1, CFG_ADDR, 8'h00);
    `CHK(lock_state, 4'hf)
    @(posedge mclk) clk_en <= 1'b1;
    reg_op(1'b1, CFG_ADDR, 8'hfe);
    `CHK(lock_state, 4'he)
    load(8'hff);
  endtask

  task automatic t_blocks();
    for (int i = 0; i < 4; i++) begin
      load(~(8'h01 << i));
      for (int j = 0; j < 4; j++) begin
        fl(lo[j], j == i);
        fl(hi[j], j == i);
      end
      fl(21'h0007ff, 1'b0);
      fl(21'h008000, 1'b0);
    end
  endtask

  task automatic t_small();
    load(8'h00);
    `CHK(lock_s, 4'h8)
    rd(CFG_ADDR, 8'h00);
    `CHK(rdata_s, 8'h08)
  endtask

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  initial begin
    repeat (5000) @(posedge mclk);
    fail_count++;
    report_and_stop();
  end

  initial begin
    fail_count = 0;
    num_checks = 0;
    arst_n = 1'b0;
    clk_en = 1'b1;
    nv_load = 1'b0;
    nv_data = 8'h00;
    reg_req = '0;
    flash_req = '0;
    repeat (8) @(posedge mclk);
    arst_n <= 1'b1;
    #1;
    t_reset();
    t_clear();
    t_freeze();
    t_blocks();
    t_small();
    report_and_stop();
  end
endmodule
